// ==== nbt_map.vh ====
`ifndef NBT_MAP_VH
`define NBT_MAP_VH

// User operation codes
`define NBT_OP_RESET 3'h0
`define NBT_OP_READ 3'h1
`define NBT_OP_PROG 3'h2
`define NBT_OP_ERASE 3'h3
`define NBT_OP_SCAN 3'h4

// Flash command bytes
`define NBT_C_RESET 8'hff
`define NBT_C_READ1 8'h00
`define NBT_C_READ2 8'h30
`define NBT_C_PROG1 8'h80
`define NBT_C_PROG2 8'h10
`define NBT_C_ERASE1 8'h60
`define NBT_C_ERASE2 8'hd0
`define NBT_C_STATUS 8'h70

// Array layout and markers
`define NBT_ERASED 8'hff
`define NBT_SPARE_COL 12'h800
`define NBT_LAST_BLK 11'h7ff
`define NBT_BLK_NUM 2048
`define NBT_PP_MAX 3'h4
`define NBT_ST_FAIL 0
`define NBT_ECC_LAST 9'h1ff
`define NBT_LAST_ADDR 3'h4
`define NBT_ROW_ADDR 3'h2

// Timing in ns; cycle counts at 10 ns, with 3 sync cycles added only to the busy wait and read access
`define NBT_TWP_NS 21
`define NBT_TWH_NS 10
`define NBT_TADL_NS 100
`define NBT_TWHR_NS 60
`define NBT_TWB_NS 100
`define NBT_TRR_NS 20
`define NBT_TREA_NS 30
`define NBT_TREH_NS 10
`define NBT_WE_LO_CYC 4'h3
`define NBT_WE_HI_CYC 4'h1
`define NBT_ADL_CYC 8'h0a
`define NBT_WHR_CYC 8'h06
`define NBT_WB_CYC 8'h0d
`define NBT_RR_CYC 8'h02
`define NBT_RE_LO_CYC 4'h7
`define NBT_RE_HI_CYC 4'h1

`endif

// ==== nbt_bbt_mem.v ====
`timescale 1ns/1ps
`include "nbt_map.vh"

module nbt_bbt_mem (
    // Clock
    input wire i_clk,
    // Write port
    input wire i_we,
    input wire [10:0] i_waddr,
    input wire i_wdata,
    // Read port
    input wire [10:0] i_raddr,
    output reg o_rdata
);
    reg mem [0:`NBT_BLK_NUM-1];

    // One bit per block, set when the block is invalid
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// ==== nbt_host.v ====
`timescale 1ns/1ps
`include "nbt_map.vh"

// Functional notes
// - Markers are scanned into the bad-block table before any erase is allowed.
// - Program and erase to a block listed as bad are refused.
// - Status is read after every program and erase, and a failed block is listed as bad.
// - Read and program data get a single-correct double-detect code per 512 bytes.
// - On a failure the block is marked bad and reported so the user can relocate pages.
// - Pages of the last programmed block are programmed in ascending order only.
// - Ascending order starts from the first page programmed, not from page zero.
// - A read or program address goes out as two column cycles and three row cycles; an erase address as three row cycles.
// - The last programmed page takes at most four partial programs before its block is erased.
module nbt_host (
    // Clock and reset
    input wire i_clk,
    input wire i_resetn,
    // Command port
    input wire i_req,
    input wire [2:0] i_op,
    input wire [16:0] i_row,
    input wire [11:0] i_col,
    input wire [11:0] i_len,
    output reg o_busy,
    output reg o_done,
    output reg o_fail,
    output reg o_refused,
    output reg o_scan_done,
    // Write data stream
    input wire [7:0] i_wr_data,
    input wire i_wr_valid,
    output reg o_wr_ready,
    // Read data stream
    output reg [7:0] o_rd_data,
    output reg o_rd_valid,
    // Check code
    output reg [12:0] o_ecc,
    output reg o_ecc_valid,
    // Flash pins
    output reg o_ce_n,
    output reg o_cle,
    output reg o_ale,
    output reg o_we_n,
    output reg o_re_n,
    output reg o_wp_n,
    input wire [7:0] i_io,
    output reg [7:0] o_io,
    output reg o_io_oe,
    input wire i_ready_busy_n
);
    localparam [3:0] S_IDLE = 4'h0, S_CHK = 4'h1, S_SEQ = 4'h2, S_CMD = 4'h3, S_ADDR = 4'h4;
    localparam [3:0] S_WDAT = 4'h5, S_RDAT = 4'h6, S_GAP = 4'h7, S_WAIT = 4'h8, S_FIN = 4'h9;
    localparam [3:0] WE_LO = `NBT_WE_LO_CYC;
    localparam [3:0] WE_END = `NBT_WE_LO_CYC + `NBT_WE_HI_CYC;
    localparam [3:0] RE_LO = `NBT_RE_LO_CYC;
    localparam [3:0] RE_END = `NBT_RE_LO_CYC + `NBT_RE_HI_CYC;
    localparam [7:0] ADL_C = `NBT_ADL_CYC;
    localparam [7:0] WHR_C = `NBT_WHR_CYC;
    localparam [7:0] WB_C = `NBT_WB_CYC;
    localparam [7:0] RR_C = `NBT_RR_CYC;

    reg [3:0] state_q, stp_q, ph_q;
    reg [2:0] op_q, a_q, pp_q;
    reg [16:0] row_q;
    reg [11:0] col_q, len_q, cnt_q;
    reg [7:0] gap_q, stat_q, io_s1_q, io_s2_q, io_s3_q;
    reg chk_q, rb_s1_q, rb_s2_q, rb_s3_q, rb_q;
    reg [10:0] lb_blk_q, bbt_wa_q;
    reg [5:0] lb_pg_q;
    reg lb_v_q, bbt_we_q, bbt_wd_q;
    reg [12:0] ecc_q;
    reg [8:0] eidx_q;
    wire bbt_bad;
    wire [10:0] blk = row_q[16:6];
    wire [5:0] pg = row_q[5:0];
    wire wr_op = (op_q == `NBT_OP_PROG) || (op_q == `NBT_OP_ERASE);
    wire st_fail = stat_q[`NBT_ST_FAIL];
    wire mark_bad = (stat_q != `NBT_ERASED);
    wire order_bad = (op_q == `NBT_OP_PROG) && lb_v_q && (lb_blk_q == blk) &&
        ((pg < lb_pg_q) || ((pg == lb_pg_q) && (pp_q == `NBT_PP_MAX)));
    wire ecc_wr = (state_q == S_WDAT) && (ph_q == 4'h0) && o_wr_ready && i_wr_valid;
    wire ecc_rd = (state_q == S_RDAT) && (ph_q == RE_LO) && (op_q == `NBT_OP_READ);
    wire [7:0] ecc_din = ecc_wr ? i_wr_data : io_s3_q;
    wire ecc_end = (eidx_q == `NBT_ECC_LAST) || (cnt_q + 12'h1 == len_q);
    wire [12:0] ecc_nx = ecc_q ^ ecc_byte(ecc_din, eidx_q);

    // Parity bit plus xor of the positions of all set bits
    function [12:0] ecc_byte;
        input [7:0] d;
        input [8:0] idx;
        integer i;
        begin
            ecc_byte = 13'h0000;
            for (i = 0; i < 8; i = i + 1) begin
                if (d[i]) begin
                    ecc_byte = ecc_byte ^ {1'b1, idx, i[2:0]};
                end
            end
        end
    endfunction

    // Five address bytes, column first
    function [7:0] addr_byte;
        input [2:0] a;
        input [11:0] c;
        input [16:0] r;
        begin
            case (a)
                3'h0: addr_byte = c[7:0];
                3'h1: addr_byte = {4'h0, c[11:8]};
                3'h2: addr_byte = r[7:0];
                3'h3: addr_byte = r[15:8];
                default: addr_byte = {7'h00, r[16]};
            endcase
        end
    endfunction

    nbt_bbt_mem u_bbt (
        .i_clk(i_clk),
        .i_we(bbt_we_q),
        .i_waddr(bbt_wa_q),
        .i_wdata(bbt_wd_q),
        .i_raddr(blk),
        .o_rdata(bbt_bad)
    );

    // Pin synchronisers
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            io_s1_q <= 8'h00;
            io_s2_q <= 8'h00;
            io_s3_q <= 8'h00;
            rb_s1_q <= 1'b0;
            rb_s2_q <= 1'b0;
            rb_s3_q <= 1'b0;
            rb_q <= 1'b0;
        end else begin
            io_s1_q <= i_io;
            io_s2_q <= io_s1_q;
            io_s3_q <= io_s2_q;
            rb_s1_q <= i_ready_busy_n;
            rb_s2_q <= rb_s1_q;
            rb_s3_q <= rb_s2_q;
            if (rb_s2_q == rb_s3_q) begin
                rb_q <= rb_s3_q;
            end
        end
    end

    // Check code per 512-byte unit
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ecc_q <= 13'h0000;
            eidx_q <= 9'h000;
            o_ecc <= 13'h0000;
            o_ecc_valid <= 1'b0;
        end else begin
            o_ecc_valid <= 1'b0;
            if (state_q == S_CHK) begin
                ecc_q <= 13'h0000;
                eidx_q <= 9'h000;
            end else if (ecc_wr || ecc_rd) begin
                if (ecc_end) begin
                    o_ecc <= ecc_nx;
                    o_ecc_valid <= 1'b1;
                    ecc_q <= 13'h0000;
                    eidx_q <= 9'h000;
                end else begin
                    ecc_q <= ecc_nx;
                    eidx_q <= eidx_q + 9'h001;
                end
            end
        end
    end

    // Operation sequencer and pin engine
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= S_IDLE;
            stp_q <= 4'h0;
            ph_q <= 4'h0;
            op_q <= 3'h0;
            a_q <= 3'h0;
            pp_q <= 3'h0;
            row_q <= 17'h00000;
            col_q <= 12'h000;
            len_q <= 12'h000;
            cnt_q <= 12'h000;
            gap_q <= 8'h00;
            stat_q <= 8'h00;
            chk_q <= 1'b0;
            lb_blk_q <= 11'h000;
            lb_pg_q <= 6'h00;
            lb_v_q <= 1'b0;
            bbt_we_q <= 1'b0;
            bbt_wa_q <= 11'h000;
            bbt_wd_q <= 1'b0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_fail <= 1'b0;
            o_refused <= 1'b0;
            o_scan_done <= 1'b0;
            o_wr_ready <= 1'b0;
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
            o_ce_n <= 1'b1;
            o_cle <= 1'b0;
            o_ale <= 1'b0;
            o_we_n <= 1'b1;
            o_re_n <= 1'b1;
            o_wp_n <= 1'b1;
            o_io <= 8'h00;
            o_io_oe <= 1'b0;
        end else begin
            o_done <= 1'b0;
            o_rd_valid <= 1'b0;
            bbt_we_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (i_req) begin
                        o_busy <= 1'b1;
                        o_fail <= 1'b0;
                        o_refused <= 1'b0;
                        op_q <= i_op;
                        row_q <= i_row;
                        col_q <= i_col;
                        len_q <= i_len;
                        chk_q <= 1'b0;
                        state_q <= S_CHK;
                        if (i_op == `NBT_OP_SCAN) begin
                            row_q <= 17'h00000;
                            col_q <= `NBT_SPARE_COL;
                            len_q <= 12'h001;
                            o_scan_done <= 1'b0;
                        end
                    end
                end
                S_CHK: begin
                    chk_q <= 1'b1;
                    if (chk_q) begin
                        if ((wr_op && !o_scan_done) ||
                            (wr_op && bbt_bad) || order_bad) begin
                            o_refused <= 1'b1;
                            state_q <= S_FIN;
                        end else begin
                            o_ce_n <= 1'b0;
                            stp_q <= 4'h0;
                            state_q <= S_SEQ;
                        end
                    end
                end
                S_SEQ: begin
                    stp_q <= stp_q + 4'h1;
                    o_cle <= 1'b0;
                    o_ale <= 1'b0;
                    cnt_q <= 12'h000;
                    ph_q <= 4'h0;
                    case (op_q)
                        `NBT_OP_RESET: begin
                            case (stp_q)
                                4'h0: begin o_io <= `NBT_C_RESET; state_q <= S_CMD; end
                                4'h1: begin gap_q <= WB_C; state_q <= S_WAIT; end
                                default: state_q <= S_FIN;
                            endcase
                        end
                        `NBT_OP_READ, `NBT_OP_SCAN: begin
                            case (stp_q)
                                4'h0: begin o_io <= `NBT_C_READ1; state_q <= S_CMD; end
                                4'h1: begin a_q <= 3'h0; state_q <= S_ADDR; end
                                4'h2: begin o_io <= `NBT_C_READ2; state_q <= S_CMD; end
                                4'h3: begin gap_q <= WB_C; state_q <= S_WAIT; end
                                4'h4: begin gap_q <= RR_C; state_q <= S_GAP; end
                                4'h5: state_q <= S_RDAT;
                                default: begin
                                    if (op_q != `NBT_OP_SCAN) begin
                                        state_q <= S_FIN;
                                    end else if (mark_bad || pg[0]) begin
                                        bbt_we_q <= 1'b1;
                                        bbt_wa_q <= blk;
                                        bbt_wd_q <= mark_bad;
                                        stp_q <= 4'h0;
                                        row_q <= {blk + 11'h001, 6'h00};
                                        if (blk == `NBT_LAST_BLK) begin
                                            o_scan_done <= 1'b1;
                                            state_q <= S_FIN;
                                        end
                                    end else begin
                                        stp_q <= 4'h0;
                                        row_q <= {blk, 6'h01};
                                    end
                                end
                            endcase
                        end
                        default: begin
                            case (stp_q)
                                4'h0: begin
                                    o_io <= (op_q == `NBT_OP_PROG) ? `NBT_C_PROG1 : `NBT_C_ERASE1;
                                    state_q <= S_CMD;
                                end
                                4'h1: begin
                                    a_q <= (op_q == `NBT_OP_PROG) ? 3'h0 : `NBT_ROW_ADDR;
                                    state_q <= S_ADDR;
                                end
                                4'h2: begin
                                    if (op_q == `NBT_OP_PROG) begin
                                        gap_q <= ADL_C;
                                        state_q <= S_GAP;
                                    end
                                end
                                4'h3: begin
                                    if (op_q == `NBT_OP_PROG) begin
                                        state_q <= S_WDAT;
                                    end
                                end
                                4'h4: begin
                                    o_io <= (op_q == `NBT_OP_PROG) ? `NBT_C_PROG2 : `NBT_C_ERASE2;
                                    state_q <= S_CMD;
                                end
                                4'h5: begin gap_q <= WB_C; state_q <= S_WAIT; end
                                4'h6: begin o_io <= `NBT_C_STATUS; state_q <= S_CMD; end
                                4'h7: begin gap_q <= WHR_C; state_q <= S_GAP; end
                                4'h8: begin len_q <= 12'h001; state_q <= S_RDAT; end
                                default: begin
                                    state_q <= S_FIN;
                                    if (st_fail) begin
                                        o_fail <= 1'b1;
                                        bbt_we_q <= 1'b1;
                                        bbt_wa_q <= blk;
                                        bbt_wd_q <= 1'b1;
                                        if (lb_blk_q == blk) begin
                                            lb_v_q <= 1'b0;
                                        end
                                    end else if (op_q == `NBT_OP_ERASE) begin
                                        if (lb_blk_q == blk) begin
                                            lb_v_q <= 1'b0;
                                        end
                                    end else begin
                                        lb_v_q <= 1'b1;
                                        lb_blk_q <= blk;
                                        lb_pg_q <= pg;
                                        pp_q <= (lb_v_q && lb_blk_q == blk && lb_pg_q == pg) ?
                                            pp_q + 3'h1 : 3'h1;
                                    end
                                end
                            endcase
                        end
                    endcase
                end
                S_CMD, S_ADDR, S_WDAT: begin
                    if (ph_q == 4'h0) begin
                        if (state_q == S_WDAT && !(o_wr_ready && i_wr_valid)) begin
                            o_wr_ready <= 1'b1;
                        end else begin
                            o_wr_ready <= 1'b0;
                            o_cle <= (state_q == S_CMD);
                            o_ale <= (state_q == S_ADDR);
                            o_io_oe <= 1'b1;
                            o_we_n <= 1'b0;
                            ph_q <= 4'h1;
                            if (state_q == S_ADDR) begin
                                o_io <= addr_byte(a_q, col_q, row_q);
                            end else if (state_q == S_WDAT) begin
                                o_io <= i_wr_data;
                            end
                        end
                    end else if (ph_q == WE_END) begin
                        ph_q <= 4'h0;
                        if (state_q == S_CMD) begin
                            state_q <= S_SEQ;
                        end else if (state_q == S_ADDR) begin
                            a_q <= a_q + 3'h1;
                            if (a_q == `NBT_LAST_ADDR) begin
                                state_q <= S_SEQ;
                            end
                        end else begin
                            cnt_q <= cnt_q + 12'h001;
                            if (cnt_q + 12'h001 == len_q) begin
                                state_q <= S_SEQ;
                            end
                        end
                    end else begin
                        if (ph_q == WE_LO) begin
                            o_we_n <= 1'b1;
                        end
                        ph_q <= ph_q + 4'h1;
                    end
                end
                S_RDAT: begin
                    o_io_oe <= 1'b0;
                    if (ph_q == 4'h0) begin
                        o_re_n <= 1'b0;
                        ph_q <= 4'h1;
                    end else if (ph_q == RE_END) begin
                        ph_q <= 4'h0;
                        cnt_q <= cnt_q + 12'h001;
                        if (cnt_q + 12'h001 == len_q) begin
                            state_q <= S_SEQ;
                        end
                    end else begin
                        if (ph_q == RE_LO) begin
                            o_re_n <= 1'b1;
                            stat_q <= io_s3_q;
                            if (op_q == `NBT_OP_READ) begin
                                o_rd_data <= io_s3_q;
                                o_rd_valid <= 1'b1;
                            end
                        end
                        ph_q <= ph_q + 4'h1;
                    end
                end
                S_GAP: begin
                    o_io_oe <= 1'b0;
                    gap_q <= gap_q - 8'h01;
                    if (gap_q <= 8'h01) begin
                        state_q <= S_SEQ;
                    end
                end
                S_WAIT: begin
                    o_io_oe <= 1'b0;
                    if (gap_q != 8'h00) begin
                        gap_q <= gap_q - 8'h01;
                    end else if (rb_q) begin
                        state_q <= S_SEQ;
                    end
                end
                S_FIN: begin
                    o_done <= 1'b1;
                    o_busy <= 1'b0;
                    o_ce_n <= 1'b1;
                    o_io_oe <= 1'b0;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

// ==== nbt_flash_model.sv ====
`timescale 1ns/1ps
module nbt_flash_model (
    // Host pins
    input wire i_ce_n,
    input wire i_cle,
    input wire i_ale,
    input wire i_we_n,
    input wire i_re_n,
    input wire [7:0] i_io,
    input wire i_io_oe,
    // Forced status failure
    input wire i_fail,
    // Resolved bus and ready/busy
    output wire [7:0] o_bus,
    output reg o_rb_n = 1,
    output integer o_viol = 0
);
    logic [7:0] m[int];
    logic [7:0] a[5];
    logic [7:0] cmd = 0, dq = 0, st = 8'he0;
    logic drv = 0;
    int na = 0, col, row, bt, pp[int], top[int];
    // Released bus shows the inverted last byte
    assign o_bus = i_io_oe ? i_io : (drv ? dq : ~dq);
    function automatic bit bad(int b);
        return b == 2 || (b >= 8 && b != 2047);
    endfunction
    function automatic logic [7:0] rd(int r, int c);
        if (m.exists(r * 4096 + c)) return m[r * 4096 + c];
        if (c == 2048 && bad(r >> 6) && (r % 64) == ((r >> 6) == 2)) return 8'h00;
        return 8'hff;
    endfunction
    always @(posedge i_we_n) if (!i_ce_n) begin
        if (!o_rb_n && !(i_cle && i_io == 8'hff)) o_viol++;
        bt = 0;
        if (i_cle) begin
            cmd = i_io;
            na = 0;
            case (i_io)
                8'hff: bt = 500;
                8'h30: bt = 200;
                8'h10: begin
                    if (top.exists(row >> 6) && (row % 64) < top[row >> 6]) o_viol++;
                    top[row >> 6] = row % 64;
                    pp[row] = pp.exists(row) ? pp[row] + 1 : 1;
                    if (pp[row] > 4 || bad(row >> 6)) o_viol++;
                    st = {7'h70, i_fail};
                    bt = 300;
                end
                8'hd0: begin
                    row = {a[2][0], a[1], a[0]};
                    if (bad(row >> 6)) o_viol++;
                    top.delete(row >> 6);
                    st = {7'h70, i_fail};
                    bt = 400;
                end
            endcase
        end else if (i_ale) begin
            a[na] = i_io;
            if (na == 4) begin
                col = {a[1][3:0], a[0]};
                row = {a[4][0], a[3], a[2]};
            end
            na++;
        end else if (cmd == 8'h80) begin
            m[row * 4096 + col] = rd(row, col) & i_io;
            col++;
        end
        if (bt > 0) fork
            begin
                #50 o_rb_n = 0;
                #(bt) o_rb_n = 1;
            end
        join_none
    end
    always @(negedge i_re_n) if (!i_ce_n) begin
        dq = (cmd == 8'h70) ? st : rd(row, col);
        if (cmd != 8'h70) col++;
        #25 drv = 1;
    end
    always @(posedge i_re_n) #15 drv = 0;
endmodule

// ==== nbt_host_asserts.sv ====
`timescale 1ns/1ps
module nbt_chk (
    // Clock and reset
    input wire i_clk,
    input wire i_resetn,
    // Watched ports
    input wire i_ready_busy_n,
    input wire o_busy,
    input wire o_done,
    input wire o_fail,
    input wire o_refused,
    input wire o_scan_done,
    input wire o_ce_n,
    input wire o_cle,
    input wire o_ale,
    input wire o_we_n,
    input wire [7:0] o_io
);
    reg [2:0] ale_cnt_q;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // Address cycles since the last command
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ale_cnt_q <= 3'h0;
        end else if ($fell(o_we_n)) begin
            ale_cnt_q <= o_cle ? 3'h0 : ale_cnt_q + {2'h0, o_ale};
        end
    end
    AST_REFUSE_QUIET: assert property (o_done && o_refused |->
        $past(o_busy, 3) && !$past(o_busy, 4) && $past(o_ce_n) && $past(o_ce_n, 2))
        else $error("refused op not quiet");
    AST_NO_WRITE_PRE_SCAN: assert property ($fell(o_we_n) && o_cle && !o_scan_done |->
        o_io != 8'h80 && o_io != 8'h60) else $error("write before scan");
    AST_READY_FIRST: assert property ($fell(o_we_n) && !(o_cle && o_io == 8'hff) |->
        $past(i_ready_busy_n, 3) && $past(i_ready_busy_n, 4)) else $error("write while busy");
    AST_STATUS_FOLLOWS: assert property ($fell(o_we_n) && o_cle &&
        (o_io == 8'h10 || o_io == 8'hd0) |-> ##[1:1000] ($fell(o_we_n) && o_cle && o_io == 8'h70))
        else $error("no status read");
    AST_FIVE_ADDR: assert property ($fell(o_we_n) && o_cle &&
        (o_io == 8'h30 || o_io == 8'h10) |-> ale_cnt_q == 3'h5) else $error("not five cycles");
    AST_THREE_ADDR: assert property ($fell(o_we_n) && o_cle && o_io == 8'hd0 |->
        ale_cnt_q == 3'h3) else $error("not three cycles");
    AST_DONE_ENDS: assert property (o_done |-> !o_busy ##1 !o_done)
        else $error("done did not end op");
    AST_FAIL_WITH_DONE: assert property ($rose(o_fail) |=> o_done && !o_refused)
        else $error("fail without done");
endmodule
bind nbt_host nbt_chk i_nbt_chk (.i_clk, .i_resetn, .i_ready_busy_n, .o_busy, .o_done,
    .o_fail, .o_refused, .o_scan_done, .o_ce_n, .o_cle, .o_ale, .o_we_n, .o_io);

// ==== nbt_host_tb.sv ====
`timescale 1ns/1ps
module nbt_host_tb;
    logic i_clk = 0;
    logic i_resetn = 0;
    logic i_req = 0;
    logic i_fail = 0;
    logic [2:0] i_op = 0;
    logic [16:0] i_row = 0;
    logic [11:0] i_col = 0;
    logic [11:0] i_len = 1;
    wire o_busy, o_done, o_fail, o_refused, o_scan_done, o_wr_ready, o_rd_valid, o_ecc_valid;
    wire o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_io_oe, rb_n;
    wire [7:0] o_rd_data, o_io, bus;
    wire [12:0] o_ecc;
    logic [7:0] wb[4] = '{8'ha5, 8'h3c, 8'h0f, 8'h81};
    logic [7:0] ad[5] = '{8'hfc, 8'h07, 8'hc5, 8'hff, 8'h01};
    logic [7:0] rq[$];
    logic [12:0] ecc;
    int wi = 0, n, fail_count = 0, comparisons = 0;
    always #5 i_clk = ~i_clk;
    nbt_host i_nbt_host (.i_clk, .i_resetn, .i_req, .i_op, .i_row, .i_col, .i_len, .o_busy,
        .o_done, .o_fail, .o_refused, .o_scan_done, .i_wr_data(wb[wi[1:0]]), .i_wr_valid(1'b1),
        .o_wr_ready, .o_rd_data, .o_rd_valid, .o_ecc, .o_ecc_valid, .o_ce_n, .o_cle, .o_ale,
        .o_we_n, .o_re_n, .o_wp_n(), .i_io(bus), .o_io, .o_io_oe, .i_ready_busy_n(rb_n));
    nbt_flash_model i_nbt_flash_model (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale),
        .i_we_n(o_we_n), .i_re_n(o_re_n), .i_io(o_io), .i_io_oe(o_io_oe), .i_fail(i_fail),
        .o_bus(bus), .o_rb_n(rb_n), .o_viol());
    always @(posedge i_clk) begin
        if (o_wr_ready) wi <= wi + 1;
        if (o_rd_valid) rq.push_back(o_rd_data);
        if (o_ecc_valid) ecc <= o_ecc;
    end
    task chk(input logic [15:0] g, e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task run(input [2:0] op, input [16:0] r, input [11:0] c, l);
        i_op = op;
        i_row = r;
        i_col = c;
        i_len = l;
        wi = 0;
        rq.delete();
        i_req = 1;
        @(posedge i_clk) #1 i_req = 0;
        for (n = 0; o_done !== 1'b1 && n < 300000; n++) @(posedge i_clk) #1;
        chk(o_done, 1);
        @(posedge i_clk) #1;
    endtask
    function automatic logic [12:0] ecc_of(input int k);
        logic [12:0] e;
        logic [7:0] d;
        e = 13'h0;
        for (int i = 0; i < k; i++) begin
            d = i < 4 ? wb[i] : 8'hff;
            for (int b = 0; b < 8; b++) if (d[b]) e = e ^ {1'b1, i[8:0], b[2:0]};
        end
        return e;
    endfunction
    task t_early;
        run(3'h2, 17'h00007, 12'h0, 12'h1);
        chk(o_refused, 1);
        chk(n, 3);
    endtask
    task t_reset;
        run(3'h0, 17'h0, 12'h0, 12'h1);
        chk(i_nbt_flash_model.cmd, 8'hff);
    endtask
    task t_scan;
        run(3'h4, 17'h0, 12'h0, 12'h1);
        chk(o_scan_done, 1);
        run(3'h2, {11'd2, 6'd1}, 12'h0, 12'h1);
        chk(o_refused, 1);
        run(3'h3, {11'd9, 6'd0}, 12'h0, 12'h1);
        chk(o_refused, 1);
    endtask
    task t_prog;
        run(3'h2, 17'h1ffc5, 12'h7fc, 12'h4);
        chk(o_fail, 0);
        for (int k = 0; k < 5; k++) chk(i_nbt_flash_model.a[k], ad[k]);
        chk(ecc, ecc_of(4));
        run(3'h1, 17'h1ffc5, 12'h7fc, 12'h5);
        chk(rq.size(), 5);
        for (int k = 0; k < 5; k++) chk(rq[k], k < 4 ? wb[k] : 8'hff);
        chk(ecc, ecc_of(5));
    endtask
    task t_order;
        run(3'h2, {11'd0, 6'd7}, 12'h0, 12'h1);
        chk(o_refused, 0);
        run(3'h2, {11'd0, 6'd3}, 12'h0, 12'h1);
        chk(o_refused, 1);
        repeat (3) begin
            run(3'h2, {11'd0, 6'd7}, 12'h0, 12'h1);
            chk(o_refused, 0);
        end
        run(3'h2, {11'd0, 6'd7}, 12'h0, 12'h1);
        chk(o_refused, 1);
    endtask
    task t_fail;
        i_fail = 1;
        run(3'h2, {11'd3, 6'd0}, 12'h0, 12'h1);
        chk(o_fail, 1);
        i_fail = 0;
        run(3'h2, {11'd3, 6'd1}, 12'h0, 12'h1);
        chk(o_refused, 1);
        run(3'h3, {11'd4, 6'd0}, 12'h0, 12'h1);
        chk(o_fail, 0);
        chk(i_nbt_flash_model.a[1], 8'h01);
        chk(i_nbt_flash_model.cmd, 8'h70);
    endtask
    task report_and_stop;
        if (fail_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        #1 i_resetn = 1;
        t_early();
        t_reset();
        t_scan();
        t_prog();
        t_order();
        t_fail();
        chk(i_nbt_flash_model.o_viol, 0);
        report_and_stop();
    end
    initial begin
        #20000000;
        fail_count++;
        report_and_stop();
    end
endmodule
